// file: dsm_sweep_pkg.sv
// Register map, field positions and reset values for the modulator
// configuration and frequency sweeper block.
// Assumes a 32-bit APB master and word-aligned register indices.
package dsm_sweep_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int VAL_W = 24;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAC = 8'h10;
  localparam logic [7:0] IDX_SEED = 8'h11;
  localparam logic [7:0] IDX_MCFG = 8'h12;
  localparam logic [7:0] IDX_SCTL = 8'h14;
  localparam logic [7:0] IDX_STEP = 8'h15;
  localparam logic [7:0] IDX_NSTEPS = 8'h16;
  localparam logic [7:0] IDX_DWELL = 8'h17;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_CURFRAC = 8'h21;

  // Modulator configuration fields
  localparam int MC_W = 18;
  localparam int MC_REF_CLK = 0;
  localparam int MC_CLK_INV = 1;
  localparam int MC_RPH_INV = 2;
  localparam int MC_INT_MODE = 3;
  localparam int MC_SIN_SEL = 6;
  localparam int MC_AUTOSEED = 7;
  localparam int MC_ORDER_LO = 8;
  localparam int MC_QMAX_LO = 10;
  localparam int MC_QMIN_LO = 14;
  // Writable bits: reserved 5:4 stay zero
  localparam logic [MC_W-1:0] MC_WMASK = 18'h3ffcf;
  localparam logic [MC_W-1:0] MC_RESET = 18'h30e82;

  // Sweep control fields
  localparam int SC_W = 8;
  localparam int SC_CLR = 0;
  localparam int SC_EN = 1;
  localparam int SC_TRIG = 2;
  localparam int SC_REPEAT = 3;
  localparam int SC_DIR_DN = 4;
  localparam int SC_EXT_EN = 5;
  localparam int SC_SSTEP = 6;
  localparam int SC_SDIR = 7;
  localparam logic [SC_W-1:0] SC_RESET = 8'h00;

  localparam logic [VAL_W-1:0] STEP_RESET = 24'h000800;
  localparam logic [VAL_W-1:0] NSTEPS_RESET = 24'h000800;
  localparam logic [VAL_W-1:0] DWELL_RESET = 24'h000800;
  localparam logic [VAL_W-1:0] FRAC_RESET = 24'h000000;
  localparam logic [VAL_W-1:0] SEED_RESET = 24'h000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_DWELL = 2'b10
  } sweep_state_e;

endpackage : dsm_sweep_pkg

// file: dsm_quant_clamp.sv
// Registered clamp of the modulator quantizer output.
// Assumes quantizer samples arrive on pclk as 4-bit two's complement.
`timescale 1ns/1ns
module dsm_quant_clamp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] quant_in,
  input wire logic [3:0] quant_max,
  input wire logic [3:0] quant_min,
  input wire logic bypass,
  output logic [3:0] quant_out
);

  logic [3:0] clamp_d;
  logic [3:0] quant_out_q;

  wire above = $signed(quant_in) > $signed(quant_max);
  wire below = $signed(quant_in) < $signed(quant_min);

  // Max is checked first, so with a crossed max/min pair an input above max still gets max
  always_comb begin
    if (bypass) begin
      clamp_d = 4'h0;
    end else if (above) begin
      clamp_d = quant_max;
    end else if (below) begin
      clamp_d = quant_min;
    end else begin
      clamp_d = quant_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quant_out_q <= 4'h0;
    end else begin
      quant_out_q <= clamp_d;
    end
  end

  assign quant_out = quant_out_q;

endmodule : dsm_quant_clamp

// file: dsm_config_and_freq_sweeper.sv
// Modulator configuration registers and linear frequency sweeper.
// Assumes an APB master on pclk and an asynchronous trigger pin.
// Function
// - Clock-source bit selects reference for modulator
// - Bits 1 and 2 invert clocks
// - Integer mode bypasses modulator output only
// - Sine-select picks sine external reference source
// - Autoseed loads seed on every fraction write
// - Order field selects modulator structure
// - Quantizer output clamped to maximum
// - Quantizer output clamped to signed minimum
// - Clear bit clears overflow/underflow flags
// - Enable bit runs ramp, else reset
// - Trigger only on bit rising 0 to 1
// - Repeat bit retriggers ramps automatically
// - Start-direction bit picks first ramp direction
// - External pin trigger when enabled
// - Single-step advances one step, then holds
// - Single-direction ramps hop back to start
// - Ramp adds step for step count
// - Repeat mode dwells at ramp ends
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module dsm_config_and_freq_sweeper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dsm_sweep_pkg::ADDR_W-1:0] paddr,
  input wire logic [dsm_sweep_pkg::DATA_W-1:0] pwdata,
  output logic [dsm_sweep_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic general_output_pin_three,
  input wire logic [3:0] quant_in,
  output logic [3:0] quant_out,
  output logic mod_clk_from_ref,
  output logic modulator_clock_invert,
  output logic ref_phase_invert,
  output logic integer_mode,
  output logic xref_sine_select,
  output logic [1:0] modulator_order,
  output logic seed_load,
  output logic [dsm_sweep_pkg::VAL_W-1:0] seed_value,
  output logic [dsm_sweep_pkg::VAL_W-1:0] frac_value,
  output logic sweep_overflow,
  output logic sweep_underflow,
  output logic sweep_busy
);
  import dsm_sweep_pkg::*;

  logic [MC_W-1:0] mcfg_q;
  logic [SC_W-1:0] sctl_q;
  logic [VAL_W-1:0] step_q;
  logic [VAL_W-1:0] nsteps_q;
  logic [VAL_W-1:0] dwell_q;
  logic [VAL_W-1:0] frac_q;
  logic [VAL_W-1:0] seed_q;
  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic seed_load_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  sweep_state_e state_q;
  sweep_state_e state_d;
  logic [VAL_W-1:0] cur_q;
  logic [VAL_W-1:0] cur_d;
  logic [VAL_W-1:0] cnt_q;
  logic [VAL_W-1:0] cnt_d;
  logic dir_dn_q;
  logic dir_dn_d;
  logic ovf_q;
  logic undf_q;
  logic busy_q;

  // Bus decode
  wire [7:0] idx = paddr[ADDR_W-1:2];
  wire aligned = paddr[1:0] == 2'b00;
  wire hit_frac = idx == IDX_FRAC;
  wire hit_seed = idx == IDX_SEED;
  wire hit_mcfg = idx == IDX_MCFG;
  wire hit_sctl = idx == IDX_SCTL;
  wire hit_step = idx == IDX_STEP;
  wire hit_nsteps = idx == IDX_NSTEPS;
  wire hit_dwell = idx == IDX_DWELL;
  wire hit_status = idx == IDX_STATUS;
  wire hit_cur = idx == IDX_CURFRAC;
  wire hit_any = aligned & (hit_frac | hit_seed | hit_mcfg | hit_sctl | hit_step
    | hit_nsteps | hit_dwell | hit_status | hit_cur);
  wire setup = psel & ~penable;
  wire wr_go = psel & penable & pready_q & pwrite & hit_any;
  wire wr_frac = wr_go & hit_frac;
  wire wr_sctl = wr_go & hit_sctl;
  wire wr_seed = wr_go & hit_seed;
  wire wr_mcfg = wr_go & hit_mcfg;
  wire wr_step = wr_go & hit_step;
  wire wr_nsteps = wr_go & hit_nsteps;
  wire wr_dwell = wr_go & hit_dwell;

  wire [DATA_W-1:0] rd_mux =
    !aligned ? 32'h0 :
    hit_frac ? {8'h0, frac_q} :
    hit_seed ? {8'h0, seed_q} :
    hit_mcfg ? {14'h0, mcfg_q} :
    hit_sctl ? {24'h0, sctl_q} :
    hit_step ? {8'h0, step_q} :
    hit_nsteps ? {8'h0, nsteps_q} :
    hit_dwell ? {8'h0, dwell_q} :
    hit_status ? {28'h0, state_q != ST_IDLE, dir_dn_q, undf_q, ovf_q} :
    hit_cur ? {8'h0, cur_q} : 32'h0;

  // No wait states, yet read data and pready both leave flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcfg_q <= MC_RESET;
    end else if (wr_mcfg) begin
      mcfg_q <= pwdata[MC_W-1:0] & MC_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= STEP_RESET;
    end else if (wr_step) begin
      step_q <= pwdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nsteps_q <= NSTEPS_RESET;
    end else if (wr_nsteps) begin
      nsteps_q <= pwdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_q <= DWELL_RESET;
    end else if (wr_dwell) begin
      dwell_q <= pwdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_q <= SEED_RESET;
    end else if (wr_seed) begin
      seed_q <= pwdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_q <= FRAC_RESET;
    end else if (wr_frac) begin
      frac_q <= pwdata[VAL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sctl_q <= SC_RESET;
    end else if (wr_sctl) begin
      sctl_q <= pwdata[SC_W-1:0];
    end
  end

  // Seed reloads on every fraction write while autoseed is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seed_load_q <= 1'b0;
    end else begin
      seed_load_q <= wr_frac & mcfg_q[MC_AUTOSEED];
    end
  end

  // Trigger pin is asynchronous; only the second and third stages are read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= general_output_pin_three;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  wire ramp_en = sctl_q[SC_EN];
  wire repeat_en = sctl_q[SC_REPEAT];
  wire single_dir = sctl_q[SC_SDIR];
  // A direction written together with the trigger applies to that very ramp
  wire first_dn = wr_sctl ? pwdata[SC_DIR_DN] : sctl_q[SC_DIR_DN];
  // A held trigger bit blocks further writes from starting ramps
  wire sw_trig = wr_sctl & pwdata[SC_TRIG] & ~sctl_q[SC_TRIG];
  wire ext_trig = sctl_q[SC_EXT_EN] & ext_s2_q & ~ext_s3_q;
  wire trig = sw_trig | ext_trig;
  wire sstep = wr_sctl & pwdata[SC_SSTEP] & ~sctl_q[SC_SSTEP];

  wire [VAL_W:0] up_sum = {1'b0, cur_q} + {1'b0, step_q};
  wire [VAL_W:0] dn_diff = {1'b0, cur_q} - {1'b0, step_q};
  wire [VAL_W-1:0] next_val = dir_dn_q ? dn_diff[VAL_W-1:0] : up_sum[VAL_W-1:0];
  wire last_step = cnt_q <= 24'h000001;
  wire step_now = (state_q == ST_RAMP) | ((state_q == ST_IDLE) & sstep);
  wire wrap_up = step_now & ~dir_dn_q & up_sum[VAL_W];
  wire wrap_dn = step_now & dir_dn_q & dn_diff[VAL_W];

  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    dir_dn_d = dir_dn_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_frac) begin
          cur_d = pwdata[VAL_W-1:0];
        end
        if (trig) begin
          state_d = ST_RAMP;
          cur_d = frac_q;
          dir_dn_d = first_dn;
          cnt_d = nsteps_q;
        end else if (sstep) begin
          cur_d = next_val;
        end
      end
      ST_RAMP: begin
        cur_d = next_val;
        cnt_d = cnt_q - 24'h000001;
        if (last_step) begin
          if (single_dir) begin
            cur_d = frac_q;
          end
          if (repeat_en) begin
            state_d = ST_DWELL;
            cnt_d = dwell_q;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_DWELL: begin
        cnt_d = cnt_q - 24'h000001;
        if (!repeat_en) begin
          state_d = ST_IDLE;
        end else if (last_step) begin
          state_d = ST_RAMP;
          cnt_d = nsteps_q;
          if (!single_dir) begin
            dir_dn_d = ~dir_dn_q;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Clearing the enable bit holds the sweeper idle with its output at the fraction value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cur_q <= FRAC_RESET;
      cnt_q <= 24'h0;
      dir_dn_q <= 1'b0;
    end else if (!ramp_en) begin
      state_q <= ST_IDLE;
      cur_q <= wr_frac ? pwdata[VAL_W-1:0] : frac_q;
      cnt_q <= 24'h0;
      dir_dn_q <= first_dn;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      cnt_q <= cnt_d;
      dir_dn_q <= dir_dn_d;
    end
  end

  // A wrap in the same cycle as the clear still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 1'b0;
      undf_q <= 1'b0;
    end else begin
      ovf_q <= (ramp_en & wrap_up) | (ovf_q & ~sctl_q[SC_CLR]);
      undf_q <= (ramp_en & wrap_dn) | (undf_q & ~sctl_q[SC_CLR]);
    end
  end

  // Busy has a flop of its own so the pin never shows a decode glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= ramp_en & (state_d != ST_IDLE);
    end
  end

  dsm_quant_clamp u_clamp (
    .pclk(pclk),
    .presetn(presetn),
    .quant_in(quant_in),
    .quant_max(mcfg_q[MC_QMAX_LO+3:MC_QMAX_LO]),
    .quant_min(mcfg_q[MC_QMIN_LO+3:MC_QMIN_LO]),
    .bypass(mcfg_q[MC_INT_MODE]),
    .quant_out(quant_out)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mod_clk_from_ref = mcfg_q[MC_REF_CLK];
  assign modulator_clock_invert = mcfg_q[MC_CLK_INV];
  assign ref_phase_invert = mcfg_q[MC_RPH_INV];
  assign integer_mode = mcfg_q[MC_INT_MODE];
  assign xref_sine_select = mcfg_q[MC_SIN_SEL];
  assign modulator_order = mcfg_q[MC_ORDER_LO+1:MC_ORDER_LO];
  assign seed_load = seed_load_q;
  assign seed_value = seed_q;
  assign frac_value = cur_q;
  assign sweep_overflow = ovf_q;
  assign sweep_underflow = undf_q;
  assign sweep_busy = busy_q;

endmodule : dsm_config_and_freq_sweeper

// file: dsm_sweep_assertions.sv
// Port checker for the modulator config and sweeper block.
// Assumes it is bound to the block's top module, byte address = 4 * index.
`timescale 1ns/1ns
module dsm_sweep_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [dsm_sweep_pkg::ADDR_W-1:0] paddr,
  input wire logic [dsm_sweep_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] quant_out,
  input wire logic integer_mode,
  input wire logic [1:0] modulator_order,
  input wire logic seed_load,
  input wire logic sweep_overflow,
  input wire logic sweep_underflow,
  input wire logic sweep_busy
);
  import dsm_sweep_pkg::*;
  logic acc;
  logic mc_wr;
  logic sc_wr;
  logic en_q;
  logic clr_q;
  logic trig_q;
  logic frac_wr;
  logic [3:0] qmax_q;
  logic [3:0] qmin_q;
  assign acc = psel && penable && pready && pwrite;
  assign mc_wr = acc && paddr == 10'h048;
  assign sc_wr = acc && paddr == 10'h050;
  assign frac_wr = acc && paddr == 10'h040;
  // Shadow copies of the control fields, updated on the same commit edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      clr_q <= 1'b0;
      trig_q <= 1'b0;
      qmax_q <= 4'h3;
      qmin_q <= 4'hc;
    end else begin
      if (sc_wr) begin
        en_q <= pwdata[1];
        clr_q <= pwdata[0];
        trig_q <= pwdata[2];
      end
      if (mc_wr) begin
        qmax_q <= pwdata[13:10];
        qmin_q <= pwdata[17:14];
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence trig_wr;
    sc_wr && pwdata[2] && pwdata[1] && en_q && !trig_q && !sweep_busy;
  endsequence
  sequence retrig_wr;
    sc_wr && pwdata[2] && trig_q && !pwdata[3] && !pwdata[5] && !pwdata[6] && !sweep_busy;
  endsequence
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  unmapped_error_a: assert property (psel && !penable && paddr == 10'h3f0 |=> pslverr)
    else $error("no error on unmapped address");
  order_write_a: assert property (mc_wr |=> modulator_order == $past(pwdata[9:8]))
    else $error("order output not updated");
  int_bypass_a: assert property (integer_mode |=> quant_out == 4'h0)
    else $error("quantizer not bypassed");
  quant_max_a: assert property (!integer_mode |=> $signed(quant_out) <= $signed($past(qmax_q)))
    else $error("quantizer above maximum");
  quant_min_a: assert property (!integer_mode |=> $signed(quant_out) >= $signed($past(qmin_q)))
    else $error("quantizer below minimum");
  seed_cause_a: assert property (seed_load |-> $past(frac_wr))
    else $error("seed load without frac write");
  enable_off_a: assert property (!en_q |=> !sweep_busy)
    else $error("busy while disabled");
  clear_flags_a: assert property (clr_q && !sweep_busy |=> !sweep_overflow && !sweep_underflow)
    else $error("flags not cleared");
  trig_start_a: assert property (trig_wr |-> ##[1:3] sweep_busy)
    else $error("trigger did not start ramp");
  retrig_block_a: assert property (retrig_wr |-> ##1 !sweep_busy [*3])
    else $error("ramp retriggered");
endmodule : dsm_sweep_checker

bind dsm_config_and_freq_sweeper dsm_sweep_checker chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata,
  .quant_out, .integer_mode, .modulator_order, .seed_load, .sweep_overflow,
  .sweep_underflow, .sweep_busy
);

// file: testbench.sv
// Self-checking bench for the modulator config and sweeper block.
// Assumes APB byte address = 4 * index and one-cycle access phase.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import dsm_sweep_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, general_output_pin_three;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] quant_in, quant_out;
  logic mod_clk_from_ref, modulator_clock_invert, ref_phase_invert, integer_mode;
  logic xref_sine_select, seed_load, sweep_overflow, sweep_underflow, sweep_busy, err;
  logic [1:0] modulator_order;
  logic [23:0] seed_value, frac_value;
  int fail_count, compares, cyc, seeds, busy_cnt, b0;
  dsm_config_and_freq_sweeper dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .general_output_pin_three, .quant_in, .quant_out, .mod_clk_from_ref,
    .modulator_clock_invert, .ref_phase_invert, .integer_mode, .xref_sine_select,
    .modulator_order, .seed_load, .seed_value, .frac_value, .sweep_overflow,
    .sweep_underflow, .sweep_busy
  );
  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction : ba
  function automatic logic [3:0] exp_q(input logic [3:0] v);
    return ($signed(v) > 4'sd3) ? 4'h3 : ($signed(v) < -4'sd4) ? 4'hc : v;
  endfunction : exp_q
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // Entered just after a rising edge; ends one edge after the release
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask : rd
  // Pin triggers need the sync delay before busy can show
  task automatic settle(input logic [23:0] e);
    repeat (6) @(posedge pclk);
    while (sweep_busy !== 1'b0) begin
      @(posedge pclk);
    end
    `CHK(frac_value, e)
  endtask : settle
  task automatic sweep(input logic [31:0] c, input logic [23:0] e);
    wr(ba(IDX_SCTL), 32'h2);
    wr(ba(IDX_SCTL), c);
    settle(e);
  endtask : sweep
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (seed_load === 1'b1) seeds++;
    if (sweep_busy === 1'b1) busy_cnt++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, general_output_pin_three} = 5'h0;
    paddr = 10'h0;
    pwdata = 32'h0;
    quant_in = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({modulator_clock_invert, modulator_order}, 3'b110)
    rd(ba(IDX_MCFG), 32'h30e82);
    rd(ba(IDX_STEP), 32'h800);
    rd(ba(IDX_NSTEPS), 32'h800);
    rd(ba(IDX_DWELL), 32'h800);
    rd(ba(IDX_SCTL), 32'h0);
    rd(10'h3f0, 32'h0);
    `CHK(err, 1'b1)
    wr(ba(IDX_MCFG), 32'hffffffff);
    rd(ba(IDX_MCFG), 32'h3ffcf);
    `CHK({mod_clk_from_ref, modulator_clock_invert, ref_phase_invert}, 3'h7)
    `CHK({integer_mode, xref_sine_select}, 2'h3)
    quant_in <= 4'h5;
    repeat (2) @(posedge pclk);
    `CHK(quant_out, 4'h0)
    for (int k = 0; k < 4; k++) begin
      wr(ba(IDX_MCFG), 32'h30c80 | (k << 8));
      `CHK(modulator_order, 2'(k))
    end
    for (int i = 0; i < 16; i++) begin
      quant_in <= 4'(i);
      repeat (2) @(posedge pclk);
      `CHK(quant_out, exp_q(4'(i)))
    end
    wr(ba(IDX_SEED), 32'h123456);
    `CHK(seed_value, 24'h123456)
    b0 = seeds;
    wr(ba(IDX_FRAC), 32'h10);
    repeat (3) @(posedge pclk);
    `CHK(seeds, b0 + 1)
    wr(ba(IDX_MCFG), 32'h30f00);
    wr(ba(IDX_FRAC), 32'h10);
    repeat (3) @(posedge pclk);
    `CHK(seeds, b0 + 1)
    wr(ba(IDX_STEP), 32'h1);
    wr(ba(IDX_NSTEPS), 32'h3);
    sweep(32'h06, 24'h13);
    b0 = busy_cnt;
    wr(ba(IDX_SCTL), 32'h06);
    settle(24'h13);
    `CHK(busy_cnt, b0)
    sweep(32'h16, 24'h0d);
    sweep(32'h86, 24'h10);
    sweep(32'h42, 24'h11);
    wr(ba(IDX_FRAC), 32'hfffffe);
    sweep(32'h06, 24'h1);
    `CHK(sweep_overflow, 1'b1)
    rd(ba(IDX_STATUS), 32'h1);
    wr(ba(IDX_SCTL), 32'h3);
    // The clear bit lands at the commit edge and acts one edge later
    @(posedge pclk);
    `CHK({sweep_overflow, sweep_underflow}, 2'b00)
    wr(ba(IDX_FRAC), 32'h1);
    sweep(32'h16, 24'hfffffe);
    `CHK(sweep_underflow, 1'b1)
    wr(ba(IDX_DWELL), 32'h2);
    wr(ba(IDX_FRAC), 32'h10);
    wr(ba(IDX_NSTEPS), 32'h2);
    wr(ba(IDX_SCTL), 32'h2);
    wr(ba(IDX_SCTL), 32'he);
    repeat (40) @(posedge pclk);
    `CHK(sweep_busy, 1'b1)
    `CHK(frac_value >= 24'h10 && frac_value <= 24'h12, 1'b1)
    wr(ba(IDX_SCTL), 32'h0);
    @(posedge pclk);
    `CHK({sweep_busy, frac_value}, {1'b0, 24'h10})
    wr(ba(IDX_SCTL), 32'h22);
    general_output_pin_three <= 1'b1;
    settle(24'h12);
    general_output_pin_three <= 1'b0;
    give_verdict();
  end
endmodule : testbench
